// *** hw/conv_ctrl.sv ***
// Conversion sequencer with result framing and the serial host port.
`timescale 1ns/1ps
module conv_ctrl
  import conv_pkg::*;
#(
  parameter int N_CH = 8,
  parameter int RAW_W = 26,
  parameter int DATA_PERIOD_CLK = 8192
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic start_pin,
  input wire logic single_shot,
  input wire logic [N_CH-1:0][RAW_W-1:0] chan_raw,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic din_pin,
  output logic dout_o,
  output logic dout_oe_n,
  output logic result_ready_n,
  output logic converting
);
  localparam int FW = STATUS_W + SAMPLE_W * N_CH;
  localparam logic [31:0] FIRST_LOAD =
    32'(FILTER_RESET_FACTOR * DATA_PERIOD_CLK - 1);
  localparam logic [31:0] NEXT_LOAD = 32'(DATA_PERIOD_CLK - 1);
  if (N_CH < 1 || N_CH > 8 || RAW_W < SAMPLE_W ||
      DATA_PERIOD_CLK < 64) begin : g_chk
    $error("conv_ctrl: parameter values not supported");
  end

  typedef enum logic {ST_IDLE, ST_CONV} conv_state_t;

  ser_if #(.FW(FW)) sbus ();

  serial_port u_port (
    .core_clk(core_clk),
    .nrst(nrst),
    .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin),
    .din_pin(din_pin),
    .dout_o(dout_o),
    .dout_oe_n(dout_oe_n),
    .bus(sbus.port)
  );

  // Out-of-range values saturate instead of wrapping.
  function automatic logic [23:0] clip24(input logic [RAW_W-1:0] v);
    logic [RAW_W-24:0] top;
    top = v[RAW_W-1:23];
    if ((&top) || !(|top)) begin
      clip24 = v[23:0];
    end else if (v[RAW_W-1]) begin
      clip24 = CODE_NEG_FS;
    end else begin
      clip24 = CODE_POS_FS;
    end
  endfunction : clip24

  logic st_s1_r, st_s2_r, st_s3_r, st_f_r, st_f_nxt;
  logic st_rise, st_fall, start_evt, stop_evt, done;

  always_comb begin
    st_f_nxt = (st_s2_r == st_s3_r) ? st_s3_r : st_f_r;
    st_rise = st_f_nxt & ~st_f_r;
    st_fall = ~st_f_nxt & st_f_r;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_s1_r <= 1'b0;
      st_s2_r <= 1'b0;
      st_s3_r <= 1'b0;
      st_f_r <= 1'b0;
    end else begin
      st_s1_r <= start_pin;
      st_s2_r <= st_s1_r;
      st_s3_r <= st_s2_r;
      st_f_r <= st_f_nxt;
    end
  end

  assign start_evt = st_rise | sbus.start_cmd;
  assign stop_evt = st_fall | sbus.stop_cmd;

  conv_state_t state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic halt_r, halt_nxt, halt_late_r, halt_late_nxt;
  logic rdy_n_r, rdy_n_nxt, new_data_r, new_data_nxt;
  logic [2:0] hi_cnt_r, hi_cnt_nxt;
  logic [FW-1:0] frame_r, frame_nxt;

  assign done = (state_r == ST_CONV) && (cnt_r == 32'h0) && !start_evt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    halt_nxt = halt_r;
    halt_late_nxt = halt_late_r;
    rdy_n_nxt = rdy_n_r;
    hi_cnt_nxt = hi_cnt_r;
    frame_nxt = frame_r;
    new_data_nxt = 1'b0;
    // Serial clock pulls the strobe high even when deselected, but not in single-shot mode while idle.
    if (sbus.sclk_fall && !(single_shot && state_r == ST_IDLE)) begin
      rdy_n_nxt = 1'b1;
    end
    if (hi_cnt_r != 3'h0) begin
      hi_cnt_nxt = 3'(hi_cnt_r - 3'h1);
      rdy_n_nxt = (hi_cnt_r == 3'h1) ? 1'b0 : 1'b1;
    end
    case (state_r)
      ST_IDLE: begin
        if (start_evt) begin
          state_nxt = ST_CONV;
          cnt_nxt = FIRST_LOAD;
          halt_nxt = 1'b0;
          halt_late_nxt = 1'b0;
          rdy_n_nxt = 1'b1;
          hi_cnt_nxt = 3'h0;
        end
      end
      ST_CONV: begin
        if (start_evt) begin
          // A start while running resynchronises the filter.
          cnt_nxt = FIRST_LOAD;
          halt_nxt = 1'b0;
          halt_late_nxt = 1'b0;
          rdy_n_nxt = 1'b1;
          hi_cnt_nxt = 3'h0;
        end else begin
          if (stop_evt) begin
            if (cnt_r >= HALT_SETUP_TIME_CLK) begin
              halt_nxt = 1'b1;
            end else begin
              halt_late_nxt = 1'b1;
            end
          end
          if (cnt_r == 32'h0) begin
            frame_nxt[FW-1 -: STATUS_W] = STATUS_WORD;
            for (int i = 0; i < N_CH; i++) begin
              frame_nxt[FW-1-STATUS_W-i*SAMPLE_W -: SAMPLE_W] =
                clip24(chan_raw[i]);
            end
            new_data_nxt = 1'b1;
            // In continuous mode an unread result is replaced behind a short high pulse.
            if (!rdy_n_r && !single_shot) begin
              hi_cnt_nxt = REFILL_HIGH_CLK;
              rdy_n_nxt = 1'b1;
            end else begin
              rdy_n_nxt = 1'b0;
              hi_cnt_nxt = 3'h0;
            end
            if (single_shot || halt_r || stop_evt) begin
              state_nxt = ST_IDLE;
            end else begin
              cnt_nxt = NEXT_LOAD;
              halt_nxt = halt_late_r;
              halt_late_nxt = 1'b0;
            end
          end else begin
            cnt_nxt = cnt_r - 32'h1;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      cnt_r <= 32'h0;
      halt_r <= 1'b0;
      halt_late_r <= 1'b0;
      rdy_n_r <= 1'b1;
      hi_cnt_r <= 3'h0;
      frame_r <= '0;
      new_data_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      halt_r <= halt_nxt;
      halt_late_r <= halt_late_nxt;
      rdy_n_r <= rdy_n_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      frame_r <= frame_nxt;
      new_data_r <= new_data_nxt;
    end
  end

  assign sbus.frame = frame_r;
  assign sbus.new_data = new_data_r;
  assign result_ready_n = rdy_n_r;
  assign converting = (state_r == ST_CONV);

  sequence s_trigger;
    (state_r == ST_IDLE) && start_evt;
  endsequence
  sequence s_filter_restart;
    (state_r == ST_CONV) && (cnt_r == FIRST_LOAD) && rdy_n_r;
  endsequence

  a_trigger_restart: assert property (
    @(posedge core_clk) disable iff (!nrst)
    s_trigger |=> s_filter_restart)
    else $error("trigger did not restart the filter");
  a_single_one_conv: assert property (
    @(posedge core_clk) disable iff (!nrst)
    done && single_shot |=> (state_r == ST_IDLE) && !rdy_n_r)
    else $error("single-shot did not halt with strobe low");
  a_single_holds_low: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (state_r == ST_IDLE) && single_shot && !rdy_n_r && !start_evt
      && $stable(single_shot) |=> !rdy_n_r)
    else $error("single-shot strobe left low state");
  a_early_halt: assert property (
    @(posedge core_clk) disable iff (!nrst)
    done && halt_r |=> state_r == ST_IDLE)
    else $error("conversion continued after early stop");
  a_late_one_more: assert property (
    @(posedge core_clk) disable iff (!nrst)
    done && !single_shot && !halt_r && !stop_evt |=>
      (state_r == ST_CONV) && (cnt_r == NEXT_LOAD)
      && (halt_r == $past(halt_late_r)))
    else $error("continuous reload wrong");
  a_clip_positive: assert property (
    @(posedge core_clk) disable iff (!nrst)
    done && !chan_raw[0][RAW_W-1] && (|chan_raw[0][RAW_W-1:23]) |=>
      frame_r[FW-1-STATUS_W -: SAMPLE_W] == CODE_POS_FS)
    else $error("positive overrange did not saturate");
  a_refill_pulse: assert property (
    @(posedge core_clk) disable iff (!nrst)
    done && !single_shot && !rdy_n_r && !halt_r && !stop_evt
      ##1 !start_evt [*4] |-> $past(rdy_n_r, 3) && $past(rdy_n_r, 2)
      && $past(rdy_n_r) && rdy_n_r ##1 !rdy_n_r)
    else $error("unread result pulse not four clocks");
  a_sclk_lifts_ready: assert property (
    @(posedge core_clk) disable iff (!nrst)
    sbus.sclk_fall && !(single_shot && state_r == ST_IDLE) && !done
      && (hi_cnt_r == 3'h0) |=> rdy_n_r)
    else $error("serial clock fall did not lift result-ready");
endmodule : conv_ctrl

// *** hw/serial_port.sv ***
// Four-wire serial port: pin synchronisers, command decode and data shifter.
`timescale 1ns/1ps
module serial_port
  import conv_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic din_pin,
  output logic dout_o,
  output logic dout_oe_n,
  ser_if.port bus
);
  localparam int FW = $bits(bus.frame);
  if (FW < 8 || FW > 65535) begin : g_chk
    $error("serial_port: frame width out of range");
  end

  // Bit 2 chip select, bit 1 serial clock, bit 0 data in.
  logic [2:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
  logic rise, fall;
  logic [2:0] in_cnt_r, in_cnt_nxt;
  logic [6:0] in_sr_r, in_sr_nxt;
  logic [15:0] out_idx_r, out_idx_nxt;
  logic dout_r, dout_nxt;
  logic start_r, start_nxt, stop_r, stop_nxt, fall_r;

  // A level counts only once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
    end
    rise = filt_nxt[1] & ~filt_r[1];
    fall = ~filt_nxt[1] & filt_r[1];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= PIN_RST;
      s2_r <= PIN_RST;
      s3_r <= PIN_RST;
      filt_r <= PIN_RST;
    end else begin
      s1_r <= {cs_n_pin, sclk_pin, din_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  always_comb begin
    in_cnt_nxt = in_cnt_r;
    in_sr_nxt = in_sr_r;
    out_idx_nxt = out_idx_r;
    dout_nxt = dout_r;
    start_nxt = 1'b0;
    stop_nxt = 1'b0;
    if (filt_r[2]) begin
      // Deselect is the only way out of a half-shifted command.
      in_cnt_nxt = 3'h0;
      out_idx_nxt = 16'h0000;
      dout_nxt = 1'b0;
    end else begin
      if (rise) begin
        dout_nxt = bus.frame[FW - 1 - int'(out_idx_r)];
        out_idx_nxt = (int'(out_idx_r) == FW - 1) ? 16'h0000 :
                      16'(out_idx_r + 16'h0001);
      end
      if (fall) begin
        in_sr_nxt = {in_sr_r[5:0], filt_nxt[0]};
        in_cnt_nxt = 3'(in_cnt_r + 3'h1);
        // Decoded while data shifts out on the other line.
        if (in_cnt_r == CMD_DECODE_BIT) begin
          start_nxt = ({in_sr_r[5:0], filt_nxt[0]} == CMD7_START);
          stop_nxt = ({in_sr_r[5:0], filt_nxt[0]} == CMD7_STOP);
        end
      end
      if (bus.new_data) begin
        out_idx_nxt = 16'h0000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      in_cnt_r <= 3'h0;
      in_sr_r <= 7'h00;
      out_idx_r <= 16'h0000;
      dout_r <= 1'b0;
      start_r <= 1'b0;
      stop_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      in_cnt_r <= in_cnt_nxt;
      in_sr_r <= in_sr_nxt;
      out_idx_r <= out_idx_nxt;
      dout_r <= dout_nxt;
      start_r <= start_nxt;
      stop_r <= stop_nxt;
      fall_r <= fall;
    end
  end

  assign dout_o = dout_r;
  assign dout_oe_n = filt_r[2];
  assign bus.start_cmd = start_r;
  assign bus.stop_cmd = stop_r;
  assign bus.sclk_fall = fall_r;

  a_cs_resets_port: assert property (
    @(posedge core_clk) disable iff (!nrst)
    filt_r[2] && filt_nxt[2] |=> (in_cnt_r == 3'h0)
      && (out_idx_r == 16'h0000) && dout_oe_n && !dout_r)
    else $error("port not held in reset while deselected");
  a_cmd_on_seventh: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (start_r || stop_r) |-> $past(fall) && ($past(in_cnt_r) == 3'h6))
    else $error("command acted on wrong serial clock edge");
  a_fall_any_select: assert property (
    @(posedge core_clk) disable iff (!nrst)
    fall |=> bus.sclk_fall && (!$past(filt_r[2]) || $stable(in_sr_r)))
    else $error("serial clock fall not reported");
  a_dout_on_rise: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $changed(dout_r) |-> $past(rise) || $past(filt_r[2]))
    else $error("data out changed off a rising edge");
endmodule : serial_port

// *** pkg/conv_pkg.sv ***
// Shared constants for the conversion control and serial port block.
package conv_pkg;
  localparam int SAMPLE_W = 24;
  localparam int STATUS_W = 24;
  localparam logic [23:0] CODE_POS_FS = 24'h7FFFFF;
  localparam logic [23:0] CODE_NEG_FS = 24'h800000;
  localparam logic [23:0] STATUS_WORD = 24'hC00000;
  // Commands are recognised from their first seven bits.
  localparam logic [6:0] CMD7_START = 7'h04;
  localparam logic [6:0] CMD7_STOP = 7'h05;
  localparam logic [2:0] CMD_DECODE_BIT = 3'h6;
  localparam logic [31:0] HALT_SETUP_TIME_CLK = 32'h10;
  localparam logic [31:0] HALT_HOLD_TIME_CLK = 32'h10;
  localparam logic [2:0] REFILL_HIGH_CLK = 3'h4;
  localparam int FILTER_RESET_FACTOR = 4;
  localparam logic [2:0] PIN_RST = 3'h4;
endpackage : conv_pkg

// *** pkg/ser_if.sv ***
// Events and frame data passed between the serial port and the sequencer.
`timescale 1ns/1ps
interface ser_if #(parameter int FW = 216);
  logic sclk_fall;
  logic start_cmd;
  logic stop_cmd;
  logic new_data;
  logic [FW-1:0] frame;
  modport port (output sclk_fall, output start_cmd, output stop_cmd,
                input new_data, input frame);
  modport ctrl (input sclk_fall, input start_cmd, input stop_cmd,
                output new_data, output frame);
endinterface : ser_if

// *** tb/host_model.sv ***
// Host serial master model: chip select, serial clock and data in.
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk,
  input wire logic dout,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // Select for whole transactions only; the gap before deselect covers
  // the four master clocks needed after the last serial clock.
  task automatic sel(input logic lvl);
    tick(6);
    cs_n = lvl;
    // A released data line must not keep showing its last value.
    if (lvl) din = ~din;
    tick(8);
  endtask : sel
  // Eight full clocks of 80 ns; data changes with the rising edge and the
  // reply is read late in the low phase.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      din = tx[i];
      tick(4);
      sclk = 1'b0;
      tick(4);
      rx = {rx[6:0], dout};
    end
  endtask : xfer
  task automatic pulse();
    sclk = 1'b1;
    tick(4);
    sclk = 1'b0;
    tick(8);
  endtask : pulse
endmodule : host_model

// *** tb/tb.sv ***
// Self-checking bench for the conversion sequencer and serial port.
`timescale 1ns/1ps
module tb;
  import conv_pkg::*;
  localparam int NC = 2;
  localparam int RW = 26;
  localparam int DP = 1024;
  logic core_clk, nrst, start_pin, single_shot;
  logic [NC-1:0][RW-1:0] chan_raw;
  logic cs_n, sclk, din, dout_o, dout_oe_n, result_ready_n, converting;
  logic rr_q, cv_q, sc_q, cv_at8;
  logic [7:0] rx;
  int failures, n_compared, n_falls, cyc, fall_cyc, cnv_cyc;
  int seed, sc_falls, r, f0;
  logic [RW-1:0] pat [6] = '{26'h1FFFFFF, 26'h2000000, 26'h07FFFFF,
                             26'h0800000, 26'h3800000, 26'h37FFFFF};
  conv_ctrl #(.N_CH(NC), .RAW_W(RW), .DATA_PERIOD_CLK(DP)) uut (
    .core_clk(core_clk), .nrst(nrst), .start_pin(start_pin),
    .single_shot(single_shot), .chan_raw(chan_raw), .cs_n_pin(cs_n),
    .sclk_pin(sclk), .din_pin(din), .dout_o(dout_o),
    .dout_oe_n(dout_oe_n), .result_ready_n(result_ready_n),
    .converting(converting));
  host_model host (.core_clk(core_clk), .dout(dout_o), .cs_n(cs_n),
    .sclk(sclk), .din(din));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Sampled on the falling edge so that every register has settled.
  always @(negedge core_clk) begin
    cyc++;
    if (rr_q && !result_ready_n) begin
      n_falls++;
      fall_cyc = cyc;
    end
    if (!cv_q && converting) cnv_cyc = cyc;
    if (sc_q && !sclk && !cs_n) begin
      sc_falls++;
      if (sc_falls == 8) cv_at8 = converting;
    end
    rr_q = result_ready_n;
    cv_q = converting;
    sc_q = sclk;
  end
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  function automatic logic [23:0] sat(input logic [RW-1:0] v);
    int s;
    s = $signed(v);
    if (s > 8388607) return CODE_POS_FS;
    if (s < -8388608) return CODE_NEG_FS;
    return v[23:0];
  endfunction : sat
  task automatic wait_fall(input int lim);
    int n0;
    n0 = n_falls;
    repeat (lim) if (n_falls == n0) @(posedge core_clk);
    #1;
    chk_word(24'(n_falls - n0), 24'h1);
  endtask : wait_fall
  task automatic count_falls(input int span, input int exp);
    int n0;
    n0 = n_falls;
    tick(span);
    chk_word(24'(n_falls - n0), 24'(exp));
  endtask : count_falls
  // Expected frame: status word, then each channel saturated to 24 bits.
  task automatic read_frame();
    logic [23:0] q[$];
    logic [23:0] w;
    q.push_back(STATUS_WORD);
    for (int c = 0; c < NC; c++) q.push_back(sat(chan_raw[c]));
    host.sel(1'b0);
    chk_bit(dout_oe_n, 1'b0);
    foreach (q[k]) begin
      for (int b = 0; b < 3; b++) begin
        host.xfer(8'h00, rx);
        w = {w[15:0], rx};
      end
      chk_word(w, q[k]);
    end
    chk_bit(result_ready_n, 1'b1);
    host.sel(1'b1);
    chk_bit(dout_oe_n, 1'b1);
  endtask : read_frame
  task automatic stop_test();
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    #(800_000);
    failures++;
    stop_test();
  end
  initial begin
    seed = 8;
    nrst = 1'b0;
    // Inputs wander during reset; outputs must not follow them.
    r = $random(seed);
    start_pin = r[0];
    single_shot = r[1];
    chan_raw = {NC{r[25:0]}};
    rr_q = 1'b1;
    cv_q = 1'b0;
    sc_q = 1'b0;
    tick(16);
    chk_word(24'({result_ready_n, dout_oe_n, converting}), 24'h6);
    start_pin = 1'b0;
    single_shot = 1'b0;
    nrst = 1'b1;
    tick(2);
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      chan_raw[0] = (k < 3) ? pat[2 * k] : RW'(r[25:0]);
      chan_raw[1] = (k < 3) ? pat[2 * k + 1] : {{2{r[23]}}, r[23:0]};
      if (k == 0) begin
        start_pin = 1'b1;
        wait_fall(5 * DP);
        chk_word(24'(fall_cyc - cnv_cyc), 24'(4 * DP));
      end else begin
        f0 = fall_cyc;
        wait_fall(DP + 8);
        chk_word(24'(fall_cyc - f0), 24'(DP));
      end
      read_frame();
    end
    // Serial clock with chip select high still lifts result-ready.
    wait_fall(DP + 8);
    host.pulse();
    chk_bit(result_ready_n, 1'b1);
    chk_bit(dout_oe_n, 1'b1);
    chk_bit(converting, 1'b1);
    tick(100);
    start_pin = 1'b0;
    count_falls(3 * DP, 1);
    chk_bit(converting, 1'b0);
    // A stop inside the last 16 clocks lets one more conversion run.
    start_pin = 1'b1;
    wait_fall(5 * DP);
    tick(DP - 16);
    start_pin = 1'b0;
    count_falls(3 * DP, 2);
    chk_bit(converting, 1'b0);
    host.sel(1'b0);
    host.xfer(8'h08, rx);
    host.sel(1'b1);
    wait_fall(5 * DP);
    // Left unread, the next result shows behind a short high pulse.
    f0 = fall_cyc;
    wait_fall(DP + 8);
    chk_word(24'(fall_cyc - f0), 24'(DP) + 24'(REFILL_HIGH_CLK));
    tick(100);
    host.sel(1'b0);
    host.xfer(8'h0A, rx);
    host.sel(1'b1);
    count_falls(3 * DP, 1);
    chk_bit(converting, 1'b0);
    single_shot = 1'b1;
    sc_falls = 0;
    host.sel(1'b0);
    host.xfer(8'h08, rx);
    chk_bit(cv_at8, 1'b1);
    host.sel(1'b1);
    wait_fall(5 * DP);
    chk_word(24'(fall_cyc - cnv_cyc), 24'(4 * DP));
    tick(4);
    chk_bit(converting, 1'b0);
    host.pulse();
    count_falls(2 * DP, 0);
    chk_bit(result_ready_n, 1'b0);
    start_pin = 1'b1;
    wait_fall(5 * DP);
    chk_word(24'(fall_cyc - cnv_cyc), 24'(4 * DP));
    count_falls(2 * DP, 0);
    chk_bit(converting, 1'b0);
    start_pin = 1'b0;
    stop_test();
  end
endmodule : tb
